// ---- hw/gateway_pkg.sv ----
// constants of the control-byte gateway: bit positions, characters, timing
// assumes one 200 MHz system clock and a controller image refreshed cyclically
// Behaviour
// - with a multi-drop node selected, prefix the outgoing telegram with its address
// - transparent mode passes serial bytes other than control characters upstream unmodified, no control bits needed
// - only bytes fitting one transfer frame go upstream; the rest are dropped
// - an idle gap over 20 ms delimits one unframed telegram from the next
// - the first zero byte ends the telegram
// - non-printable control characters in the data are treated as invalid and dropped
// - in command mode no controller data bytes reach the serial device
// - in command mode serial answers still flow upstream as usual
// - a command bit sends STX, command character, CR, LF, unless a handheld is selected
// - serial answers go upstream without delay; the code publishes a set only at the zero byte or the idle gap
// - the device-selection switch is sampled at startup and sets the handling
// - with a multi-drop node selected, the broadcast bit prepends 00B so every node receives the data
// - data loss flag is set when data is lost or truncated
// - upstream new-data toggle inverts for every data set sent
package gateway_pkg;
   localparam int         CLK_MHZ      = 200;
   localparam int         GAP_MS       = 20;
   localparam int         GAP_CYCLES   = GAP_MS * 1000 * CLK_MHZ;
   localparam int         CB_CMD_MODE  = 0;
   localparam int         CB_BCAST     = 1;
   localparam int         CB_ADDR_LO   = 2;
   localparam int         CB_ADDR_W    = 5;
   localparam int         CB_TOGGLE    = 7;
   localparam int         CMD_VERSION  = 0;
   localparam int         CMD_GATE     = 1;
   localparam int         SEL_W        = 4;
   localparam int         SYNC_STAGES  = 2;
   localparam int         FIFO_DEPTH   = 16;
   localparam int         DATA_BYTES   = 8;
   localparam int         FRAME_BYTES  = 8;
   localparam logic [3:0] SEL_MULTIDROP = 4'h1;
   localparam logic [3:0] SEL_HANDHELD  = 4'h2;
   localparam logic [4:0] ADDR_TEN     = 5'h0A;
   localparam logic [7:0] CH_NUL       = 8'h00;
   localparam logic [7:0] CH_STX       = 8'h02;
   localparam logic [7:0] CH_LF        = 8'h0A;
   localparam logic [7:0] CH_CR        = 8'h0D;
   localparam logic [7:0] CH_SPACE     = 8'h20;
   localparam logic [7:0] CH_PLUS      = 8'h2B;
   localparam logic [7:0] CH_MINUS     = 8'h2D;
   localparam logic [7:0] CH_ZERO      = 8'h30;
   localparam logic [7:0] CH_BEE       = 8'h42;
   localparam logic [7:0] CH_VER       = 8'h76;
   localparam logic [7:0] CH_DEL       = 8'h7F;
   localparam logic [1:0] BCAST_LEN    = 2'h3;

   typedef enum logic [1:0] {
      A_COLLECT = 2'b00,
      A_PUBLISH = 2'b01
   } asm_state_t;

   typedef enum logic [2:0] {
      T_IDLE  = 3'b000,
      T_BCAST = 3'b001,
      T_ADDR  = 3'b010,
      T_DATA  = 3'b011,
      T_STX   = 3'b100,
      T_CMD   = 3'b101,
      T_CR    = 3'b110,
      T_LF    = 3'b111
   } tx_state_t;
endpackage

// ---- hw/gateway_byte_fifo.sv ----
// synchronous FIFO for the upstream byte path
// assumes one clock; first-word output read combinationally from the array
`timescale 1ns/1ps
module gateway_byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   // full when the pointers differ only in the wrap bit
   always_comb begin
      in_ready    = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
      out_valid   = wr_ptr != rd_ptr;
      out_data    = mem[rd_ptr[AW-1:0]];
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule

// ---- hw/gateway_control_byte_framer.sv ----
// control-byte gateway: controller image to serial telegrams and back
// assumes serial bytes arrive as one-cycle strobes on sys_clk; dev_sel is a raw switch pin
`timescale 1ns/1ps
module gateway_control_byte_framer
   import gateway_pkg::*;
#(
   parameter int GAP_CYC = gateway_pkg::GAP_CYCLES,
   parameter int NDATA   = gateway_pkg::DATA_BYTES,
   parameter int NFRAME  = gateway_pkg::FRAME_BYTES
) (
   input  wire logic                      sys_clk,
   input  wire logic                      rstn,
   input  wire logic [7:0]                output_control_byte_zero,
   input  wire logic [NDATA*8-1:0]        data_image,
   input  wire logic [gateway_pkg::SEL_W-1:0] dev_sel,
   input  wire logic                      ser_rx_valid,
   input  wire logic [7:0]                ser_rx_data,
   input  wire logic                      ser_tx_ready,
   output logic                           ser_tx_valid,
   output logic      [7:0]                ser_tx_data,
   input  wire logic                      up_ready,
   output logic      [NFRAME*8-1:0]       up_frame,
   output logic      [7:0]                up_len,
   output logic                           new_data_toggle,
   output logic                           data_loss_flag
);
   import gateway_pkg::*;
   localparam int CW = $clog2(NFRAME + 1);
   localparam int IW = $clog2(NDATA + 1);

   function automatic logic is_invalid(input logic [7:0] b);
      is_invalid = (b != CH_NUL) && ((b < CH_SPACE) || (b == CH_DEL));
   endfunction

   // startup switch capture
   logic [SEL_W-1:0] sel_meta, sel_sync, dev_type;
   logic [1:0]       sel_wait;
   logic             sel_done;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sel_meta <= '0;
         sel_sync <= '0;
         dev_type <= '0;
         sel_wait <= '0;
         sel_done <= 1'b0;
      end else begin
         sel_meta <= dev_sel;
         sel_sync <= sel_meta;
         sel_wait <= (sel_wait == 2'(SYNC_STAGES)) ? sel_wait : sel_wait + 2'h1;
         if (!sel_done && sel_wait == 2'(SYNC_STAGES)) begin
            dev_type <= sel_sync;
            sel_done <= 1'b1;
         end
      end
   end
   wire multidrop = sel_done && dev_type == SEL_MULTIDROP;
   wire handheld  = sel_done && dev_type == SEL_HANDHELD;

   // upstream: gap timer, filtering, FIFO
   logic [31:0] gap_cnt, next_gap_cnt;
   logic        open_tg, next_open_tg, skip, next_skip;
   logic        fin_valid, fin_ready, gap_hit;
   logic [8:0]  fin_data;
   wire         rx_nul = ser_rx_data == CH_NUL;
   always_comb begin
      gap_hit      = open_tg && !ser_rx_valid && gap_cnt == 32'(GAP_CYC - 1);
      next_gap_cnt = (ser_rx_valid || gap_hit) ? '0 : (open_tg ? gap_cnt + 32'h1 : gap_cnt);
      next_open_tg = ser_rx_valid || (open_tg && !gap_hit);
      next_skip    = (ser_rx_valid && rx_nul) || (skip && !gap_hit);
      fin_valid    = 1'b0;
      fin_data     = {1'b0, ser_rx_data};
      if (ser_rx_valid && !skip && rx_nul) begin
         fin_valid = 1'b1;
         fin_data  = {1'b1, CH_NUL};
      end else if (ser_rx_valid && !skip && !is_invalid(ser_rx_data)) begin
         fin_valid = 1'b1;
      end else if (gap_hit && !skip) begin
         fin_valid = 1'b1;
         fin_data  = {1'b1, CH_NUL};
      end
   end

   logic       fout_valid, fout_ready;
   logic [8:0] fout_data;
   gateway_byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .in_valid  (fin_valid),
      .in_ready  (fin_ready),
      .in_data   (fin_data),
      .out_valid (fout_valid),
      .out_ready (fout_ready),
      .out_data  (fout_data)
   );

   // frame assembly; stalls on the controller, which back-pressures the FIFO
   asm_state_t        a_state, next_a_state;
   logic [NFRAME*8-1:0] frame_buf, next_frame_buf, next_up_frame;
   logic [CW-1:0]     cnt, next_cnt;
   logic              pend_loss, next_pend_loss, next_toggle, next_loss_flag;
   logic [7:0]        next_up_len;
   logic              publish;
   always_comb begin
      next_a_state   = a_state;
      next_frame_buf = frame_buf;
      next_cnt       = cnt;
      next_up_frame  = up_frame;
      next_up_len    = up_len;
      next_toggle    = new_data_toggle;
      next_loss_flag = data_loss_flag;
      fout_ready     = a_state == A_COLLECT;
      publish        = a_state == A_PUBLISH && up_ready;
      next_pend_loss = (pend_loss && !publish) || (fin_valid && !fin_ready);
      if (a_state == A_COLLECT && fout_valid) begin
         if (fout_data[8]) begin
            if (cnt != '0) next_a_state = A_PUBLISH;
         end else if (cnt < CW'(NFRAME)) begin
            next_frame_buf[cnt*8 +: 8] = fout_data[7:0];
            next_cnt = cnt + 1'b1;
         end else begin
            next_pend_loss = 1'b1;
         end
      end
      if (publish) begin
         next_up_frame  = frame_buf;
         next_up_len    = 8'(cnt);
         next_toggle    = !new_data_toggle;
         next_loss_flag = pend_loss || (fin_valid && !fin_ready);
         next_frame_buf = '0;
         next_cnt       = '0;
         next_a_state   = A_COLLECT;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gap_cnt         <= '0;
         open_tg         <= 1'b0;
         skip            <= 1'b0;
         a_state         <= A_COLLECT;
         frame_buf       <= '0;
         cnt             <= '0;
         pend_loss       <= 1'b0;
         up_frame        <= '0;
         up_len          <= '0;
         new_data_toggle <= 1'b0;
         data_loss_flag  <= 1'b0;
      end else begin
         gap_cnt         <= next_gap_cnt;
         open_tg         <= next_open_tg;
         skip            <= next_skip;
         a_state         <= next_a_state;
         frame_buf       <= next_frame_buf;
         cnt             <= next_cnt;
         pend_loss       <= next_pend_loss;
         up_frame        <= next_up_frame;
         up_len          <= next_up_len;
         new_data_toggle <= next_toggle;
         data_loss_flag  <= next_loss_flag;
      end
   end

   // downstream: requests from the control byte and command bits
   wire        cmd_mode = output_control_byte_zero[CB_CMD_MODE];
   wire [4:0]  addr     = output_control_byte_zero[CB_ADDR_LO +: CB_ADDR_W];
   wire [7:0]  cmd_byte = data_image[7:0];
   logic       tog_q, gate_q, ver_q;
   logic       pend_data, pend_plus, pend_minus, pend_ver;
   logic       next_pend_data, next_pend_plus, next_pend_minus, next_pend_ver;
   tx_state_t  t_state, next_t_state;
   logic [IW-1:0] idx, next_idx;
   logic [NDATA*8-1:0] snap, next_snap;
   logic [7:0] cmd_char, next_cmd_char, next_tx_data;
   logic       next_tx_valid, tx_free, go_cmd, req_data, req_plus, req_minus, req_ver;
   logic [7:0] cur;
   always_comb begin
      tx_free         = !ser_tx_valid || ser_tx_ready;
      go_cmd          = cmd_mode && !handheld;
      // a request landing while the old one is served stays pending: set wins
      req_data        = output_control_byte_zero[CB_TOGGLE] != tog_q && !cmd_mode;
      req_plus        = go_cmd && cmd_byte[CMD_GATE] && !gate_q;
      req_minus       = go_cmd && !cmd_byte[CMD_GATE] && gate_q;
      req_ver         = go_cmd && cmd_byte[CMD_VERSION] && !ver_q;
      next_pend_data  = pend_data || req_data;
      next_pend_plus  = pend_plus || req_plus;
      next_pend_minus = pend_minus || req_minus;
      next_pend_ver   = pend_ver || req_ver;
      next_t_state    = t_state;
      next_idx        = idx;
      next_snap       = snap;
      next_cmd_char   = cmd_char;
      next_tx_valid   = tx_free ? 1'b0 : ser_tx_valid;
      next_tx_data    = ser_tx_data;
      cur             = snap[idx*8 +: 8];
      if (tx_free) begin
         case (t_state)
            T_IDLE: begin
               next_idx = '0;
               if (pend_data) begin
                  next_pend_data = req_data;
                  next_snap      = data_image;
                  if (multidrop && output_control_byte_zero[CB_BCAST]) next_t_state = T_BCAST;
                  else if (multidrop) next_t_state = T_ADDR;
                  else next_t_state = T_DATA;
               end else if (pend_plus || pend_minus || pend_ver) begin
                  next_cmd_char = pend_plus ? CH_PLUS : (pend_minus ? CH_MINUS : CH_VER);
                  if (pend_plus) next_pend_plus = req_plus;
                  else if (pend_minus) next_pend_minus = req_minus;
                  else next_pend_ver = req_ver;
                  next_t_state = T_STX;
               end
            end
            T_BCAST: begin
               next_tx_valid = 1'b1;
               next_tx_data  = (idx == IW'(BCAST_LEN - 2'h1)) ? CH_BEE : CH_ZERO;
               next_idx      = idx + 1'b1;
               if (idx == IW'(BCAST_LEN - 2'h1)) begin
                  next_idx     = '0;
                  next_t_state = T_DATA;
               end
            end
            T_ADDR: begin
               next_tx_valid = 1'b1;
               next_tx_data  = CH_ZERO + 8'((idx == '0) ? addr / ADDR_TEN : addr % ADDR_TEN);
               next_idx      = idx + 1'b1;
               if (idx != '0) begin
                  next_idx     = '0;
                  next_t_state = T_DATA;
               end
            end
            T_DATA: begin
               // zero padding ends the set; the snapshot keeps mid-send edits out
               if (idx == IW'(NDATA) || cur == CH_NUL) begin
                  next_t_state = T_IDLE;
               end else begin
                  next_tx_valid = 1'b1;
                  next_tx_data  = cur;
                  next_idx      = idx + 1'b1;
               end
            end
            T_STX: begin
               next_tx_valid = 1'b1;
               next_tx_data  = CH_STX;
               next_t_state  = T_CMD;
            end
            T_CMD: begin
               next_tx_valid = 1'b1;
               next_tx_data  = cmd_char;
               next_t_state  = T_CR;
            end
            T_CR: begin
               next_tx_valid = 1'b1;
               next_tx_data  = CH_CR;
               next_t_state  = T_LF;
            end
            T_LF: begin
               next_tx_valid = 1'b1;
               next_tx_data  = CH_LF;
               next_t_state  = T_IDLE;
            end
            default: next_t_state = T_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tog_q        <= 1'b0;
         gate_q       <= 1'b0;
         ver_q        <= 1'b0;
         pend_data    <= 1'b0;
         pend_plus    <= 1'b0;
         pend_minus   <= 1'b0;
         pend_ver     <= 1'b0;
         t_state      <= T_IDLE;
         idx          <= '0;
         snap         <= '0;
         cmd_char     <= CH_NUL;
         ser_tx_valid <= 1'b0;
         ser_tx_data  <= CH_NUL;
      end else begin
         tog_q        <= output_control_byte_zero[CB_TOGGLE];
         gate_q       <= cmd_byte[CMD_GATE];
         ver_q        <= cmd_byte[CMD_VERSION];
         pend_data    <= next_pend_data;
         pend_plus    <= next_pend_plus;
         pend_minus   <= next_pend_minus;
         pend_ver     <= next_pend_ver;
         t_state      <= next_t_state;
         idx          <= next_idx;
         snap         <= next_snap;
         cmd_char     <= next_cmd_char;
         ser_tx_valid <= next_tx_valid;
         ser_tx_data  <= next_tx_data;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_stx_sent;
      ser_tx_valid && ser_tx_ready && ser_tx_data == CH_STX && t_state == T_CMD;
   endsequence
   sequence s_cmd_tail;
      ser_tx_valid && ser_tx_ready && ser_tx_data == cmd_char && t_state == T_CR;
   endsequence
   sequence s_cr_sent;
      ser_tx_valid && ser_tx_ready && ser_tx_data == CH_CR && t_state == T_LF;
   endsequence

   a_cmd_frame: assert property (s_stx_sent |=> ser_tx_valid && ser_tx_data == cmd_char)
      else $error("command char does not follow STX");
   a_cmd_cr: assert property (s_cmd_tail |=> ser_tx_valid && ser_tx_data == CH_CR)
      else $error("CR missing after command char");
   a_cmd_crlf: assert property (s_cr_sent |=> ser_tx_valid && ser_tx_data == CH_LF)
      else $error("LF missing after CR");
   a_no_data_cmd: assert property (cmd_mode && $changed(output_control_byte_zero[CB_TOGGLE]) |=>
      !pend_data || $past(pend_data))
      else $error("data request taken in command mode");
   a_toggle_req: assert property (!cmd_mode && $changed(output_control_byte_zero[CB_TOGGLE]) |=> pend_data)
      else $error("toggle change not registered");
   a_pub_toggle: assert property (publish |=> new_data_toggle != $past(new_data_toggle))
      else $error("upstream toggle did not invert");
   a_pub_len: assert property (publish |=> up_len == 8'($past(cnt)) && up_len != 8'h00)
      else $error("published length wrong");
   a_frame_cap: assert property (cnt <= CW'(NFRAME))
      else $error("frame count over limit");
   a_gap_end: assert property (gap_hit && !skip && fin_ready |-> fin_valid && fin_data[8])
      else $error("gap did not end telegram");
   a_nul_skip: assert property (ser_rx_valid && rx_nul |=> skip [*2] or (skip ##1 !skip))
      else $error("zero byte did not truncate");
   a_bad_drop: assert property (ser_rx_valid && is_invalid(ser_rx_data) |-> !fin_valid)
      else $error("control character forwarded");
   a_loss_set: assert property (fin_valid && !fin_ready |=> pend_loss)
      else $error("lost byte not flagged");
   a_bcast_lead: assert property (t_state == T_IDLE && pend_data && tx_free && multidrop &&
      output_control_byte_zero[CB_BCAST] |=> t_state == T_BCAST)
      else $error("broadcast prefix skipped");
endmodule

// ---- test/serial_end_model.sv ----
// serial end device model: accepts telegram bytes, sends answer bytes
// assumes the bench calls its tasks; everything it drives changes at the falling edge
`timescale 1ns/1ps
module serial_end_model (
   input  wire logic       sys_clk,
   input  wire logic       stall,
   input  wire logic       ser_tx_valid,
   input  wire logic [7:0] ser_tx_data,
   output logic            ser_tx_ready,
   output logic            ser_rx_valid,
   output logic      [7:0] ser_rx_data
);
   integer     seed = 32'h4f9d;
   logic [7:0] got[$];
   initial begin
      ser_tx_ready = 1'b0;
      ser_rx_valid = 1'b0;
      ser_rx_data  = 8'hA5;
   end
   // a slow device drops ready at random, never faster than one byte a cycle
   always @(negedge sys_clk) ser_tx_ready <= stall ? 1'($random(seed)) : 1'b1;
   always @(posedge sys_clk) if (ser_tx_valid && ser_tx_ready) got.push_back(ser_tx_data);
   task send(input logic [7:0] b);
      @(negedge sys_clk);
      ser_rx_valid = 1'b1;
      ser_rx_data  = b;
   endtask
   // idle line: data keeps changing so a stale byte is never mistaken for a new one
   task gap(input int n);
      repeat (n) begin
         @(negedge sys_clk);
         ser_rx_valid = 1'b0;
         ser_rx_data  = ~ser_rx_data;
      end
   endtask
endmodule

// ---- test/tb_gateway_control_byte_framer.sv ----
// bench for the control-byte gateway: controller side driven here, serial side by the model
// assumes a short gap parameter so telegram ends come quickly
`timescale 1ns/1ps
module tb_gateway_control_byte_framer;
   import gateway_pkg::*;
   typedef logic [7:0] byteq_t[$];
   localparam int GAP = 50;
   logic        sys_clk, rstn, up_ready, stall, ser_rx_valid, ser_tx_ready, ser_tx_valid, last_tog;
   logic [7:0]  cb0, ser_rx_data, ser_tx_data, up_len;
   logic [63:0] img, up_frame;
   logic [3:0]  dev_sel;
   logic        new_data_toggle, data_loss_flag;
   logic [63:0] pf[$];
   logic [7:0]  pl[$];
   logic        pd[$];
   byteq_t      s, none;
   integer      seed = 32'h4f9d;
   int          bad_count, num_checks, cycles;

   gateway_control_byte_framer #(.GAP_CYC(GAP), .NDATA(DATA_BYTES), .NFRAME(FRAME_BYTES)) i_dut (
      .sys_clk(sys_clk), .rstn(rstn), .output_control_byte_zero(cb0), .data_image(img),
      .dev_sel(dev_sel), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
      .ser_tx_ready(ser_tx_ready), .ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data),
      .up_ready(up_ready), .up_frame(up_frame), .up_len(up_len),
      .new_data_toggle(new_data_toggle), .data_loss_flag(data_loss_flag));
   serial_end_model p (
      .sys_clk(sys_clk), .stall(stall), .ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data),
      .ser_tx_ready(ser_tx_ready), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // every toggle change is one published set
   always @(negedge sys_clk) begin
      if (rstn && new_data_toggle !== last_tog) begin
         pf.push_back(up_frame);
         pl.push_back(up_len);
         pd.push_back(data_loss_flag);
      end
      last_tog = rstn ? new_data_toggle : 1'b0;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end

   task summarize();
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [63:0] g, input logic [63:0] x);
      num_checks++;
      if (g !== x) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   function automatic logic [7:0] prn();
      return 8'h21 + 8'({$random(seed)} % 94);
   endfunction
   function automatic logic [63:0] mkimg(input int z);
      logic [63:0] r;
      for (int j = 0; j < 8; j++) r[8*j+:8] = prn();
      if (z < 8) r[8*z+:8] = CH_NUL;
      return r;
   endfunction
   // upstream view: stop at zero, drop control characters, cap at frame size
   function automatic void exp_up(input byteq_t q, output logic [63:0] f, output logic [7:0] n,
                                  output logic l);
      logic z;
      f = 64'h0;
      n = 8'h00;
      l = 1'b0;
      z = 1'b0;
      foreach (q[i]) begin
         if (q[i] == CH_NUL) z = 1'b1;
         if (!z && q[i] >= CH_SPACE && q[i] != CH_DEL) begin
            if (n < FRAME_BYTES) f[8*n+:8] = q[i];
            else l = 1'b1;
            if (n < FRAME_BYTES) n++;
         end
      end
   endfunction
   function automatic byteq_t exp_down(input byteq_t pre, input logic [63:0] im);
      byteq_t r;
      r = pre;
      for (int j = 0; j < DATA_BYTES; j++) begin
         if (im[8*j+:8] == CH_NUL) break;
         r.push_back(im[8*j+:8]);
      end
      return r;
   endfunction
   task automatic pubchk(input byteq_t q, input logic extra = 1'b0);
      logic [63:0] f;
      logic [7:0]  n;
      logic        l;
      int          w;
      exp_up(q, f, n, l);
      w = 0;
      while (pf.size() == 0 && w < 300) begin
         @(negedge sys_clk);
         w++;
      end
      if (pf.size() == 0) chk(64'h0, 64'h1);
      else begin
         chk(pf.pop_front(), f);
         chk(pl.pop_front(), n);
         chk(pd.pop_front(), l | extra);
      end
   endtask
   task automatic send_up(input byteq_t q);
      foreach (q[i]) p.send(q[i]);
      p.gap(GAP + 10);
   endtask
   task automatic cmpq(input byteq_t x);
      int w;
      w = 0;
      while (p.got.size() < x.size() && w < 200) begin
         @(negedge sys_clk);
         w++;
      end
      repeat (20) @(negedge sys_clk);
      chk(p.got.size(), x.size());
      foreach (x[i]) if (i < p.got.size()) chk(p.got[i], x[i]);
      p.got.delete();
   endtask
   // expectation built from the new image, not the one still applied
   task automatic down(input logic [63:0] im, input byteq_t pre);
      @(negedge sys_clk);
      img = im;
      cb0[7] = ~cb0[7];
      cmpq(exp_down(pre, im));
   endtask
   task automatic cmd(input logic [7:0] b2, input logic [7:0] ch);
      @(negedge sys_clk);
      img = {56'h0, b2};
      cmpq('{CH_STX, ch, CH_CR, CH_LF});
   endtask
   task automatic do_reset(input logic [3:0] sel);
      @(negedge sys_clk);
      rstn = 1'b0;
      dev_sel = sel;
      repeat (3) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
   endtask

   initial begin
      rstn = 1'b0;
      cb0 = 8'h00;
      img = 64'h0;
      dev_sel = 4'h0;
      up_ready = 1'b1;
      stall = 1'b0;
      last_tog = 1'b0;
      do_reset(4'h0);
      send_up('{8'h41, 8'h42, CH_NUL, 8'h43});
      pubchk('{8'h41, 8'h42, CH_NUL, 8'h43});
      send_up('{8'h31, CH_CR, CH_DEL, 8'h32, CH_STX});
      pubchk('{8'h31, CH_CR, CH_DEL, 8'h32, CH_STX});
      for (int k = 0; k < 4; k++) begin
         s = {};
         repeat (5 + k * 2) s.push_back(prn());
         send_up(s);
         pubchk(s);
      end
      stall = 1'b1;
      for (int k = 0; k < 4; k++) down(mkimg(1 + k * 3), none);
      down({56'h0, CH_PLUS}, none);
      down({56'h0, CH_MINUS}, none);
      // clear the command bits a cycle ahead so no stale gate edge is seen
      @(negedge sys_clk);
      img = 64'h0;
      @(negedge sys_clk);
      cb0[0] = 1'b1;
      @(negedge sys_clk);
      cb0[7] = ~cb0[7];
      cmd(8'h02, CH_PLUS);
      cmd(8'h03, CH_VER);
      cmd(8'h01, CH_MINUS);
      send_up('{8'h4F, 8'h4B, CH_NUL});
      pubchk('{8'h4F, 8'h4B, CH_NUL});
      cb0 = 8'h00;
      do_reset(SEL_MULTIDROP);
      for (int a = 0; a < 4; a++) begin
         cb0[6:2] = 5'(a);
         down(mkimg(3), '{CH_ZERO, CH_ZERO + 8'(a)});
      end
      cb0[1] = 1'b1;
      down(mkimg(2), '{CH_ZERO, CH_ZERO, CH_BEE});
      up_ready = 1'b0;
      send_up('{8'h41, CH_NUL});
      s = {};
      repeat (20) s.push_back(prn());
      send_up(s);
      @(negedge sys_clk);
      up_ready = 1'b1;
      // let the full FIFO drain so the closing zero byte is not lost as well
      repeat (20) @(negedge sys_clk);
      send_up('{CH_NUL});
      // overflow loss is reported with the next published set
      pubchk('{8'h41, CH_NUL}, 1'b1);
      pubchk(s);
      summarize();
   end
endmodule
